// file: include/fcsi_defs.vh
`ifndef FCSI_DEFS_VH
`define FCSI_DEFS_VH
// Register byte offsets.
`define FCSI_OFF_MODE 8'h00
`define FCSI_OFF_CMD 8'h04
`define FCSI_OFF_STATUS 8'h08
`define FCSI_OFF_RESULT 8'h0c
`define FCSI_OFF_IRQ_STAT 8'h10
`define FCSI_OFF_IRQ_EN 8'h14
`define FCSI_OFF_IRQ_CLR 8'h18
// Command word fields.
`define FCSI_KEY_HI 31
`define FCSI_KEY_LO 24
`define FCSI_ARG_HI 23
`define FCSI_ARG_LO 8
`define FCSI_CODE_HI 7
`define FCSI_CODE_LO 0
`define FCSI_KEY_VALUE 8'h5a
// Mode register fields.
`define FCSI_MODE_RDY_IE 0
`define FCSI_MODE_WS_HI 11
`define FCSI_MODE_WS_LO 8
`define FCSI_MODE_RESET 32'h0000_0000
// Status register bits.
`define FCSI_ST_READY 0
`define FCSI_ST_CMD_ERR 1
`define FCSI_ST_LOCK_ERR 2
`define FCSI_ST_VERIFY_ERR 3
// Command codes.
`define FCSI_CMD_GET_ID 8'h00
`define FCSI_CMD_PROGRAM 8'h01
`define FCSI_CMD_ERASE_PAGES 8'h07
`define FCSI_CMD_LOCK 8'h08
`define FCSI_CMD_ERASE_ALL 8'h05
`define FCSI_CMD_ERASE_PLANE 8'h06
`define FCSI_CMD_ERASE_SECTOR 8'h11
// Operation kinds sent to the array.
`define FCSI_OP_READ_INFO 3'h0
`define FCSI_OP_PROGRAM 3'h1
`define FCSI_OP_ERASE 3'h2
`define FCSI_OP_LOCK 3'h3
`endif

// file: rtl/fcsi_result_buf.v
`timescale 1ns/10ps
`default_nettype none
// Small result memory: loaded word by word, read out sequentially, zero past the end.
module fcsi_result_buf #(
    parameter DEPTH = 4,
    parameter AW = 2
) (
    // Clock and reset.
    input wire sys_clk,
    input wire reset_n,
    input wire clk_en,
    // Load side.
    input wire load_start,
    input wire load_valid,
    input wire [31:0] load_word,
    // Read side.
    input wire read_next,
    output reg [31:0] read_word_q
);
    reg [31:0] mem_q [0:DEPTH-1]; // Result words.
    reg [AW:0] count_q; // Number of meaningful words.
    reg [AW:0] wptr_q; // Next slot to load.
    reg [AW:0] rptr_q; // Next word to deliver.

    ////////////////////////////////////////////////////////////////////////
    // Storage writes need no reset.
    always @(posedge sys_clk) begin
        if (clk_en && load_valid && wptr_q < DEPTH) begin
            mem_q[wptr_q[AW-1:0]] <= load_word;
        end
    end

    // Pointers; the presented word always reflects the read pointer.
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            count_q <= {(AW+1){1'b0}};
            wptr_q <= {(AW+1){1'b0}};
            rptr_q <= {(AW+1){1'b0}};
            read_word_q <= 32'h0000_0000;
        end else if (clk_en) begin
            if (load_start) begin
                // New command: drop old result.
                wptr_q <= {(AW+1){1'b0}};
                count_q <= {(AW+1){1'b0}};
                rptr_q <= {(AW+1){1'b0}};
                read_word_q <= 32'h0000_0000;
            end else if (load_valid && wptr_q < DEPTH) begin
                wptr_q <= wptr_q + 1'b1;
                count_q <= count_q + 1'b1;
                // First word shows at once.
                if (wptr_q == {(AW+1){1'b0}}) begin
                    read_word_q <= load_word;
                end
            end else if (read_next) begin
                // Advance; past the end the register reads zero.
                if (rptr_q + 1'b1 < count_q) begin
                    read_word_q <= mem_q[rptr_q[AW-1:0] + 1'b1];
                end else begin
                    read_word_q <= 32'h0000_0000;
                end
                if (rptr_q < count_q) begin
                    rptr_q <= rptr_q + 1'b1;
                end
            end
        end
    end
endmodule // fcsi_result_buf
`default_nettype wire

// file: rtl/fcsi_top.v
// Notes on behaviour
// - Multi-page erase: start page, two-bit count
// - Program command: argument is target page
// - Lock command: argument is page to lock
// - Only key 0x5a starts a command
// - Ready reads zero while busy, one idle
// - Ready clears itself when busy starts
// - Ready plus enable raises interrupt
// - Bad code or key sets command error
// - Status read or command write clears errors
// - Locked target sets lock error
// - Failed verify sets verify error
// - Wide results read out word by word
// - Mode enable bit gates ready interrupt
// - Array access lasts wait states plus one
// - Reads past result end return zero
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "fcsi_defs.vh"
module fcsi_top #(
    parameter WSW = 4,
    parameter RES_DEPTH = 4,
    parameter RES_AW = 2
) (
    // Clock, reset and enable.
    input wire sys_clk,
    input wire reset_n,
    input wire clk_en,
    // Register port.
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata_q,
    // Array side request.
    output reg array_req_q,
    output reg [2:0] array_op_q,
    output reg [15:0] array_page_q,
    output reg [5:0] array_page_count_q,
    // Array side answers (same clock domain).
    input wire array_done,
    input wire array_locked,
    input wire array_verify_fail,
    input wire array_result_valid,
    input wire [31:0] array_result_word,
    // Interrupt.
    output reg irq_q
);
    localparam ST_IDLE = 2'h0;
    localparam ST_WAIT = 2'h1;
    localparam ST_RUN = 2'h2;

    reg [31:0] mode_q; // Mode register.
    reg ready_q; // Ready status bit.
    reg cmd_err_q; // Command error flag.
    reg lock_err_q; // Lock error flag.
    reg verify_err_q; // Verify error flag.
    reg [1:0] state_q; // Sequencer state.
    reg [3:0] irq_stat_q; // Sticky event bits.
    reg [3:0] irq_en_q; // Event enables.
    reg ready_prev_q; // Ready last cycle, for the rise event.
    reg [2:0] op_d; // Decoded operation.
    reg [15:0] page_d; // Decoded page.
    reg [5:0] count_d; // Decoded page count.
    reg code_ok_d; // Command code is known.
    wire [31:0] result_word; // Current result word.
    wire ws_done; // Wait time elapsed.
    wire cmd_wr; // Command register write.
    wire key_ok; // Key matches.
    wire st_rd; // Status register read.
    wire [3:0] ev_d; // Events this cycle.
    wire start_cmd; // Accepted command.

    assign cmd_wr = reg_wr && reg_addr == `FCSI_OFF_CMD;
    assign st_rd = reg_rd && reg_addr == `FCSI_OFF_STATUS;
    assign key_ok = reg_wdata[`FCSI_KEY_HI:`FCSI_KEY_LO] == `FCSI_KEY_VALUE;
    // Commands arriving while busy are not started, since software waits; the write still clears the error flags.
    assign start_cmd = cmd_wr && key_ok && code_ok_d && state_q == ST_IDLE;

    ////////////////////////////////////////////////////////////////////////
    // Decode the argument per command family.
    always @* begin
        op_d = `FCSI_OP_READ_INFO;
        page_d = reg_wdata[`FCSI_ARG_HI:`FCSI_ARG_LO];
        count_d = 6'h01;
        code_ok_d = 1'b1;
        case (reg_wdata[`FCSI_CODE_HI:`FCSI_CODE_LO])
            `FCSI_CMD_GET_ID: begin
                op_d = `FCSI_OP_READ_INFO;
            end
            `FCSI_CMD_PROGRAM: begin
                op_d = `FCSI_OP_PROGRAM;
            end
            `FCSI_CMD_LOCK: begin
                op_d = `FCSI_OP_LOCK;
            end
            `FCSI_CMD_ERASE_ALL: begin
                // Argument ignored.
                op_d = `FCSI_OP_ERASE;
                page_d = 16'h0000;
                count_d = 6'h00;
            end
            `FCSI_CMD_ERASE_PLANE, `FCSI_CMD_ERASE_SECTOR: begin
                // Any page inside the region selects it.
                op_d = `FCSI_OP_ERASE;
                count_d = 6'h00;
            end
            `FCSI_CMD_ERASE_PAGES: begin
                // Start page from upper bits, aligned down to the count.
                op_d = `FCSI_OP_ERASE;
                case (reg_wdata[`FCSI_ARG_LO+1:`FCSI_ARG_LO])
                    2'h0: count_d = 6'h04;
                    2'h1: count_d = 6'h08;
                    2'h2: count_d = 6'h10;
                    default: count_d = 6'h20;
                endcase
                page_d = {2'h0, reg_wdata[`FCSI_ARG_HI:`FCSI_ARG_LO+2]}
                    & ~{10'h000, count_d - 6'h01};
            end
            default: begin
                code_ok_d = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode register and interrupt enable/status registers.
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_q <= `FCSI_MODE_RESET;
            irq_en_q <= 4'h0;
            irq_stat_q <= 4'h0;
        end else if (clk_en) begin
            if (reg_wr && reg_addr == `FCSI_OFF_MODE) begin
                mode_q <= reg_wdata;
            end
            if (reg_wr && reg_addr == `FCSI_OFF_IRQ_EN) begin
                irq_en_q <= reg_wdata[3:0];
            end
            // New events win over a clear in the same cycle.
            if (reg_wr && reg_addr == `FCSI_OFF_IRQ_CLR) begin
                irq_stat_q <= (irq_stat_q & ~reg_wdata[3:0]) | ev_d;
            end else begin
                irq_stat_q <= irq_stat_q | ev_d;
            end
        end
    end

    // Events: ready rise, command error, lock error, verify error.
    assign ev_d = {state_q == ST_RUN && array_done && array_verify_fail,
                   state_q == ST_RUN && array_done && array_locked,
                   cmd_wr && !(key_ok && code_ok_d),
                   ready_q && !ready_prev_q};

    ////////////////////////////////////////////////////////////////////////
    // Command sequencer and status flags.
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ST_IDLE;
            ready_q <= 1'b1;
            ready_prev_q <= 1'b1;
            cmd_err_q <= 1'b0;
            lock_err_q <= 1'b0;
            verify_err_q <= 1'b0;
            array_req_q <= 1'b0;
            array_op_q <= `FCSI_OP_READ_INFO;
            array_page_q <= 16'h0000;
            array_page_count_q <= 6'h00;
        end else if (clk_en) begin
            ready_prev_q <= ready_q;
            array_req_q <= 1'b0;
            // Errors clear on status read or command write; sets below win.
            if (st_rd || cmd_wr) begin
                cmd_err_q <= 1'b0;
                lock_err_q <= 1'b0;
                verify_err_q <= 1'b0;
            end
            if (cmd_wr && !(key_ok && code_ok_d)) begin
                cmd_err_q <= 1'b1;
            end
            case (state_q)
                ST_IDLE: begin
                    if (start_cmd) begin
                        ready_q <= 1'b0;
                        array_op_q <= op_d;
                        array_page_q <= page_d;
                        array_page_count_q <= count_d;
                        state_q <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (ws_done) begin
                        array_req_q <= 1'b1;
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (array_done) begin
                        if (array_locked) begin
                            lock_err_q <= 1'b1;
                        end
                        verify_err_q <= array_verify_fail;
                        ready_q <= 1'b1;
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data mux, one cycle after the read strobe.
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata_q <= 32'h0000_0000;
            irq_q <= 1'b0;
        end else if (clk_en) begin
            // Ready plus its enable, or any enabled sticky event.
            irq_q <= (ready_q && mode_q[`FCSI_MODE_RDY_IE]) || |(irq_stat_q & irq_en_q);
            reg_rdata_q <= 32'h0000_0000;
            if (reg_rd) begin
                case (reg_addr)
                    `FCSI_OFF_MODE: reg_rdata_q <= mode_q;
                    `FCSI_OFF_STATUS: reg_rdata_q <= {28'h0000000, verify_err_q,
                        lock_err_q, cmd_err_q, ready_q};
                    `FCSI_OFF_RESULT: reg_rdata_q <= result_word;
                    `FCSI_OFF_IRQ_STAT: reg_rdata_q <= {28'h0000000, irq_stat_q};
                    `FCSI_OFF_IRQ_EN: reg_rdata_q <= {28'h0000000, irq_en_q};
                    default: reg_rdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Result buffer and wait-state timer.
    fcsi_result_buf #(
        .DEPTH(RES_DEPTH),
        .AW(RES_AW)
    ) u_result (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .load_start(start_cmd),
        .load_valid(array_result_valid && state_q == ST_RUN),
        .load_word(array_result_word),
        // Step at the strobe itself, so back-to-back reads get successive words.
        .read_next(reg_rd && reg_addr == `FCSI_OFF_RESULT),
        .read_word_q(result_word)
    );

    fcsi_wait_timer #(
        .WSW(WSW)
    ) u_wait (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .start(start_cmd),
        .wait_states(mode_q[`FCSI_MODE_WS_HI:`FCSI_MODE_WS_LO]),
        .done_q(ws_done)
    );
endmodule // fcsi_top
`default_nettype wire

// file: rtl/fcsi_wait_timer.v
`timescale 1ns/10ps
`default_nettype none
// Stretches each array access to wait-state count plus one cycles.
module fcsi_wait_timer #(
    parameter WSW = 4
) (
    // Clock and reset.
    input wire sys_clk,
    input wire reset_n,
    input wire clk_en,
    // Control.
    input wire start,
    input wire [WSW-1:0] wait_states,
    output reg done_q
);
    reg [WSW:0] left_q; // Cycles still to wait.
    reg busy_q; // Access in progress.

    ////////////////////////////////////////////////////////////////////////
    // Counts wait_states+1 cycles, then pulses done for one cycle.
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            left_q <= {(WSW+1){1'b0}};
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else if (clk_en) begin
            done_q <= 1'b0;
            if (start) begin
                left_q <= {1'b0, wait_states};
                busy_q <= 1'b1;
            end else if (busy_q) begin
                if (left_q == {(WSW+1){1'b0}}) begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end else begin
                    left_q <= left_q - 1'b1;
                end
            end
        end
    end
endmodule // fcsi_wait_timer
`default_nettype wire

// file: sim/fcsi_chk_asserts.sv
`timescale 1ns/10ps
`default_nettype none
`include "fcsi_defs.vh"
// Checks command, status and interrupt timing at the top ports.
module fcsi_chk (
    // Clock and reset.
    input wire sys_clk,
    input wire reset_n,
    // Register port.
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [31:0] reg_rdata_q,
    // Array port and interrupt.
    input wire array_req_q,
    input wire [2:0] array_op_q,
    input wire [15:0] array_page_q,
    input wire array_done,
    input wire array_locked,
    input wire array_verify_fail,
    input wire irq_q
);
    logic busy_q; // Shadow of the busy state.
    logic ie_q; // Shadow of the ready interrupt enable.
    logic [3:0] ws_q; // Shadow of the wait-state field.
    logic [5:0] cnt_q; // Cycles since the last accepted command.
    logic [15:0] arg_q; // Argument of the last accepted command.
    wire cmd_wr = reg_wr && reg_addr == `FCSI_OFF_CMD;
    wire st_rd = reg_rd && reg_addr == `FCSI_OFF_STATUS;
    wire key_ok = reg_wdata[31:24] == `FCSI_KEY_VALUE;
    wire code_ok = reg_wdata[7:0] inside {`FCSI_CMD_GET_ID, `FCSI_CMD_PROGRAM,
        `FCSI_CMD_ERASE_PAGES, `FCSI_CMD_LOCK, `FCSI_CMD_ERASE_ALL, `FCSI_CMD_ERASE_PLANE,
        `FCSI_CMD_ERASE_SECTOR};
    wire go = cmd_wr && key_ok && code_ok && !busy_q; // A command the block must start.
    ////////////////////////////////////////////////////////////////////////
    // Tracks what software asked for; the count stops at the request so a later mode
    // change cannot make it match again.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            busy_q <= 1'b0;
            ie_q <= 1'b0;
            ws_q <= 4'h0;
            cnt_q <= 6'h00;
            arg_q <= 16'h0000;
        end else begin
            if (go) begin
                busy_q <= 1'b1;
                cnt_q <= 6'h01;
                arg_q <= reg_wdata[23:8];
            end else begin
                if (array_done) begin
                    busy_q <= 1'b0;
                end
                if (array_req_q || array_done) begin
                    cnt_q <= 6'h00;
                end else if (cnt_q != 6'h00 && cnt_q != 6'h3f) begin
                    cnt_q <= cnt_q + 6'h01;
                end
            end
            if (reg_wr && reg_addr == `FCSI_OFF_MODE) begin
                ie_q <= reg_wdata[`FCSI_MODE_RDY_IE];
                ws_q <= reg_wdata[`FCSI_MODE_WS_HI:`FCSI_MODE_WS_LO];
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    a_req_after_wait: assert property (@(posedge sys_clk) disable iff (!reset_n)
        array_req_q == (cnt_q == {2'b00, ws_q} + 6'd3))
        else $error("array request not at wait states plus three");
    a_bad_key_idle: assert property (@(posedge sys_clk) disable iff (!reset_n)
        cmd_wr && !key_ok && !busy_q |=> !array_req_q [*8])
        else $error("command with wrong key started an operation");
    a_ready_status: assert property (@(posedge sys_clk) disable iff (!reset_n)
        st_rd |=> reg_rdata_q[`FCSI_ST_READY] == !$past(busy_q))
        else $error("ready bit disagrees with busy state");
    a_ready_irq: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (ie_q && !busy_q) [*2] |-> irq_q)
        else $error("ready with enable set but no interrupt");
    a_err_cleared: assert property (@(posedge sys_clk) disable iff (!reset_n)
        st_rd && !array_done ##1 st_rd |=> reg_rdata_q[3:1] == 3'h0)
        else $error("error flags survived a status read");
    a_cmd_err_set: assert property (@(posedge sys_clk) disable iff (!reset_n)
        cmd_wr && !(key_ok && code_ok) ##1 st_rd |=> reg_rdata_q[`FCSI_ST_CMD_ERR])
        else $error("command error flag not set");
    a_lock_err_set: assert property (@(posedge sys_clk) disable iff (!reset_n)
        array_done && array_locked && busy_q ##1 st_rd |=> reg_rdata_q[`FCSI_ST_LOCK_ERR])
        else $error("lock error flag not set");
    a_verify_flag: assert property (@(posedge sys_clk) disable iff (!reset_n)
        array_done && busy_q ##1 st_rd
        |=> reg_rdata_q[`FCSI_ST_VERIFY_ERR] == $past(array_verify_fail, 2))
        else $error("verify error flag wrong after operation");
    a_page_arg: assert property (@(posedge sys_clk) disable iff (!reset_n)
        array_req_q && array_op_q inside {`FCSI_OP_PROGRAM, `FCSI_OP_LOCK}
        |-> array_page_q == arg_q)
        else $error("array page differs from command argument");
endmodule // fcsi_chk
bind fcsi_top fcsi_chk i_chk (.sys_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata_q, .array_req_q, .array_op_q, .array_page_q, .array_done, .array_locked,
    .array_verify_fail, .irq_q);
`default_nettype wire

// file: sim/fcsi_flash_model.sv
`timescale 1ns/10ps
`default_nettype none
`include "fcsi_defs.vh"
// Flash array stand-in: runs each request for a set time, gives three info words.
module fcsi_flash_model (
    // Clock and reset.
    input wire sys_clk,
    input wire reset_n,
    // Settings from the bench.
    input wire [7:0] lat,
    input wire lock_set,
    input wire fail_set,
    // Array port.
    input wire array_req_q,
    input wire [2:0] array_op_q,
    output logic array_done,
    output logic array_locked,
    output logic array_verify_fail,
    output logic array_result_valid,
    output logic [31:0] array_result_word
);
    logic [7:0] cnt_q; // Cycles left in the running operation.
    logic [2:0] op_q; // Kind of the running operation.
    wire hit = op_q == `FCSI_OP_PROGRAM || op_q == `FCSI_OP_ERASE; // Writes to the array.
    // Flags mean something only with done; otherwise they show the inverse.
    assign array_done = cnt_q == 8'd1;
    assign array_locked = array_done ? lock_set && hit : !(lock_set && hit);
    assign array_verify_fail = array_done ? fail_set && hit : !(fail_set && hit);
    assign array_result_valid = op_q == `FCSI_OP_READ_INFO && cnt_q inside {8'd2, 8'd3, 8'd4};
    assign array_result_word = array_result_valid ? 32'ha5000000 + 32'(8'd4 - cnt_q)
        : ~{24'h0, cnt_q};
    // Starts a run on each request; the length is set by the bench.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= 8'd0;
            op_q <= 3'h0;
        end else if (array_req_q) begin
            cnt_q <= lat + 8'd5;
            op_q <= array_op_q;
        end else if (cnt_q != 8'd0) begin
            cnt_q <= cnt_q - 8'd1;
        end
    end
endmodule // fcsi_flash_model
`default_nettype wire

// file: sim/flash_command_status_interface_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "fcsi_defs.vh"
// Drives the register port, checks read data and array requests from queues.
module flash_command_status_interface_tb_top;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic clk_en = 1'b1; // Freezes the design while low.
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] lat = 8'h00;
    logic lock_set = 1'b0;
    logic fail_set = 1'b0;
    wire [31:0] reg_rdata_q, array_result_word;
    wire [2:0] array_op_q;
    wire [15:0] array_page_q;
    wire [5:0] array_page_count_q;
    wire array_req_q, array_done, array_locked, array_verify_fail, array_result_valid, irq_q;
    int failures = 0;
    int n_tests = 0;
    int seed = 93976;
    int cycles = 0;
    int k;
    int j;
    logic pend = 1'b0; // A read was taken at the last edge.
    logic [31:0] exp_q[$], msk_q[$], rexp_q[$], rmsk_q[$]; // Expected reads and requests.
    logic [31:0] r, e, m;
    logic [15:0] arg;
    logic [7:0] code;
    logic [7:0] codes [7] = '{8'h00, 8'h01, 8'h05, 8'h06, 8'h11, 8'h07, 8'h08};
    logic [31:0] bad [2] = '{32'h3c000101, 32'h5a0000ff}; // Wrong key, unknown code.
    fcsi_top i_dut (.sys_clk, .reset_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata_q, .array_req_q, .array_op_q, .array_page_q, .array_page_count_q,
        .array_done, .array_locked, .array_verify_fail, .array_result_valid,
        .array_result_word, .irq_q);
    fcsi_flash_model i_array (.sys_clk, .reset_n, .lat, .lock_set, .fail_set, .array_req_q,
        .array_op_q, .array_done, .array_locked, .array_verify_fail, .array_result_valid,
        .array_result_word);
    ////////////////////////////////////////////////////////////////////////
    initial begin
        forever #25 sys_clk = ~sys_clk;
    end
    // Compares the masked bits and counts the outcome.
    task automatic chk(input logic [31:0] got, input logic [31:0] ex, input logic [31:0] mk);
        n_tests++;
        if ((got & mk) !== (ex & mk)) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got & mk, ex & mk);
        end
    endtask
    // One register cycle; a read notes its expected data.
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [31:0] ex, input logic [31:0] mk);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        if (!w) begin
            exp_q.push_back(ex);
            msk_q.push_back(mk);
        end
        @(posedge sys_clk);
    endtask
    // Drops both strobes and lets some edges pass.
    task automatic idle(input int n);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        repeat (n) @(posedge sys_clk);
    endtask
    // Prints the counts and the verdict, then stops.
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Takes the oldest note whenever read data or an array request appears.
    always @(posedge sys_clk) begin
        if (pend) begin
            chk(reg_rdata_q, exp_q.pop_front(), msk_q.pop_front());
        end
        if (array_req_q) begin
            chk({7'h0, array_op_q, array_page_count_q, array_page_q}, rexp_q.pop_front(),
                rmsk_q.pop_front());
        end
        pend = reg_rd;
        cycles++;
        if (cycles == 20000) begin
            failures++;
            end_of_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        acc(1'b1, 8'h1c, 32'hffffffff, 32'h0, 32'h0);
        acc(1'b0, `FCSI_OFF_STATUS, 32'h0, 32'h1, 32'hf);
        acc(1'b0, `FCSI_OFF_MODE, 32'h0, `FCSI_MODE_RESET, 32'hffffffff);
        acc(1'b1, `FCSI_OFF_IRQ_EN, 32'h2, 32'h0, 32'h0);
        for (k = 0; k < 2; k++) begin
            acc(1'b1, `FCSI_OFF_CMD, bad[k], 32'h0, 32'h0);
            acc(1'b0, `FCSI_OFF_STATUS, 32'h0, 32'h3, 32'hf);
            acc(1'b0, `FCSI_OFF_IRQ_STAT, 32'h0, 32'h2, 32'h2);
            idle(2);
            chk({31'h0, irq_q}, 32'h1, 32'h1);
            clk_en <= 1'b0; // A frozen block must ignore this clear.
            acc(1'b1, `FCSI_OFF_IRQ_CLR, 32'h2, 32'h0, 32'h0);
            idle(2);
            chk({31'h0, irq_q}, 32'h1, 32'h1);
            clk_en <= 1'b1;
            acc(1'b1, `FCSI_OFF_IRQ_CLR, 32'h2, 32'h0, 32'h0);
            idle(3);
            chk({31'h0, irq_q}, 32'h0, 32'h1);
        end
        $display("test refusals done");
        for (k = 0; k < 28; k++) begin
            r = $random(seed);
            code = codes[k % 7];
            arg = r[31:16]; // Any page in the target region.
            lat <= {3'h0, r[4:0]};
            lock_set <= r[5];
            fail_set <= r[6];
            e = {7'h0, 3'h2, 6'h00, arg};
            m = 32'h01ffffff;
            case (code)
                8'h00: begin
                    e[24:22] = `FCSI_OP_READ_INFO;
                    m = 32'h01c00000;
                end
                8'h01: begin
                    e[24:22] = `FCSI_OP_PROGRAM;
                    m = 32'h01c0ffff;
                end
                8'h05: m = 32'h01ff0000;
                8'h07: begin
                    e[21:16] = 6'd4 << arg[1:0];
                    e[15:0] = {2'h0, arg[15:2]} & ~(16'(e[21:16]) - 16'h1);
                    m = 32'h01ffffff;
                end
                8'h08: begin
                    e[24:22] = `FCSI_OP_LOCK;
                    m = 32'h01c0ffff;
                end
                default: m = 32'h01ffffff;
            endcase
            rexp_q.push_back(e);
            rmsk_q.push_back(m);
            acc(1'b1, `FCSI_OFF_MODE, {20'h0, r[11:8], 7'h0, r[12]}, 32'h0, 32'h0);
            acc(1'b0, `FCSI_OFF_MODE, 32'h0, {20'h0, r[11:8], 7'h0, r[12]}, 32'hf01);
            acc(1'b1, `FCSI_OFF_CMD, {8'h5a, arg, code}, 32'h0, 32'h0);
            acc(1'b0, `FCSI_OFF_STATUS, 32'h0, 32'h0, 32'h1);
            idle(1);
            while (array_done !== 1'b1) @(posedge sys_clk); // Wait for the array done pulse.
            j = (code != 8'h00 && code != 8'h08);
            acc(1'b0, `FCSI_OFF_STATUS, 32'h0, {28'h0, r[6] && j, r[5] && j, 2'b01},
                32'hf);
            acc(1'b0, `FCSI_OFF_STATUS, 32'h0, 32'h1, 32'hf);
            for (j = 0; j < 5 && code == 8'h00; j++) begin
                acc(1'b0, `FCSI_OFF_RESULT, 32'h0, j < 3 ? 32'ha5000000 + j : 32'h0,
                    32'hffffffff);
            end
            idle(3);
            chk({31'h0, irq_q}, {31'h0, r[12]}, 32'h1);
        end
        $display("test commands done");
        end_of_test();
    end
endmodule // flash_command_status_interface_tb_top
`default_nettype wire
